// ==== verilog/wdog_consts.vh ====
// constants for the windowed watchdog: offsets, field positions, resets
// assumes inclusion by bare name from the watchdog design file
`ifndef WDOG_CONSTS_VH
`define WDOG_CONSTS_VH
`define OFS_RESTART_CONTROL 8'h00
`define OFS_WATCHDOG_MODE 8'h04
`define OFS_WATCHDOG_STATUS 8'h08
`define MODE_RESET_VALUE 32'h3FFF_2FFF
`define RESTART_KEY 8'hA5
`define KEY_MSB 31
`define KEY_LSB 24
`define RESTART_BIT 0
`define LOAD_MSB 11
`define LOAD_LSB 0
`define INT_EN_BIT 12
`define RST_EN_BIT 13
`define PROC_ONLY_BIT 14
`define DISABLE_BIT 15
`define DELTA_MSB 27
`define DELTA_LSB 16
`define DBG_HALT_BIT 28
`define IDLE_HALT_BIT 29
`define MODE_USED_MASK 32'h3FFF_FFFF
`define UNF_BIT 0
`define ERR_BIT 1
`define PRESCALE_DIV 8'h80
`endif

// ==== verilog/windowed_watchdog_timer.v ====
// windowed watchdog: 12-bit down counter on slow clock / 128, key-protected
// restart, write-once mode register, sticky status and fault outputs.
// assumes slow clock, debug and idle levels arrive asynchronously from pins;
// register bus strobes are synchronous to REF_CLK_I.
//
// What this block does
// - 12-bit down counter loaded from the mode load field on reload.
// - counter decrements once per slow clock divided by 128.
// - after reset load field is all ones and reset generation enabled.
// - processor reset restores initial values and counting resumes.
// - only first mode write after reset is accepted.
// - mode write reloads counter and restarts with new parameters.
// - control write acts only with key 0xA5; bit 0 requests restart.
// - permitted restart reloads counter and restarts the prescaler.
// - underflow sets its flag and, if enabled, raises fault.
// - restart above delta raises error and, with reset enable set, fault, even if disabled.
// - delta at or above load value means restarts never error.
// - mode register resets to 0x3FFF_2FFF.
// - interrupt follows flags when fault interrupt enable is set.
// - fault requests all resets or processor only, per select bit.
// - watchdog reset clears the processor, the watchdog and flags.
// - status read or reset clears flags, interrupt and fault.
// - debug halt and idle halt stop the counter in those states.
// - disable bit stops counting and underflow.
// - status bit 0 underflow, bit 1 error, sticky since last read.
`timescale 1ns/1ps
`include "wdog_consts.vh"

module windowed_watchdog_timer #(
  parameter CNT_W = 12,
  parameter PRESCALE = 128
) (
  // clock and processor reset
  input wire REF_CLK_I,
  input wire RST_N_I,
  // register port
  input wire [7:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [31:0] RDATA_O,
  // asynchronous system levels
  input wire SLOW_CLK_I,
  input wire DEBUG_STATE_I,
  input wire IDLE_MODE_I,
  // to interrupt and reset controllers
  output reg IRQ_O,
  output reg FAULT_ALL_O,
  output reg FAULT_PROC_O
);

  reg [31:0] mode_q;
  reg mode_locked_q;
  reg [CNT_W-1:0] count_q;
  reg [7:0] presc_q;
  reg unf_q;
  reg err_q;
  reg fault_q;
  reg [2:0] slow_sync_q;
  reg [1:0] dbg_sync_q;
  reg [1:0] idle_sync_q;

  wire [CNT_W-1:0] load_val = mode_q[`LOAD_MSB:`LOAD_LSB];
  wire [CNT_W-1:0] delta_val = mode_q[`DELTA_MSB:`DELTA_LSB];
  wire wr_mode = WR_I && (ADDR_I == `OFS_WATCHDOG_MODE);
  wire wr_ctrl = WR_I && (ADDR_I == `OFS_RESTART_CONTROL);
  wire rd_stat = RD_I && (ADDR_I == `OFS_WATCHDOG_STATUS);
  // key check discards the whole write otherwise
  wire restart_req = wr_ctrl && WDATA_I[`RESTART_BIT] &&
    (WDATA_I[`KEY_MSB:`KEY_LSB] == `RESTART_KEY);
  // window violation; delta >= load never errors since count <= load
  wire early = restart_req && (count_q > delta_val);
  wire restart_ok = restart_req && !early;
  wire slow_rise = slow_sync_q[1] && !slow_sync_q[2];
  wire halted = mode_q[`DISABLE_BIT] ||
    (mode_q[`DBG_HALT_BIT] && dbg_sync_q[1]) ||
    (mode_q[`IDLE_HALT_BIT] && idle_sync_q[1]);
  wire presc_wrap = (presc_q == PRESCALE[7:0] - 8'h01);
  wire tick = slow_rise && presc_wrap && !halted;
  wire underflow = tick && (count_q == {CNT_W{1'b0}});
  wire unf_set = underflow;
  wire err_set = early;
  wire fault_ev = (underflow || early) && mode_q[`RST_EN_BIT];

  // synchronisers; slow clock gets a third stage for edge detection
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      slow_sync_q <= 3'b000;
      dbg_sync_q <= 2'b00;
      idle_sync_q <= 2'b00;
    end else begin
      slow_sync_q <= {slow_sync_q[1:0], SLOW_CLK_I};
      dbg_sync_q <= {dbg_sync_q[0], DEBUG_STATE_I};
      idle_sync_q <= {idle_sync_q[0], IDLE_MODE_I};
    end
  end

  // write-once mode register; reset value enables reset generation
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mode_q <= `MODE_RESET_VALUE;
      mode_locked_q <= 1'b0;
    end else if (wr_mode && !mode_locked_q) begin
      mode_q <= WDATA_I & `MODE_USED_MASK;
      mode_locked_q <= 1'b1;
    end
  end

  // prescaler: restarted by any reload so the first tick is a full period
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      presc_q <= 8'h00;
    end else if ((wr_mode && !mode_locked_q) || restart_ok) begin
      presc_q <= 8'h00;
    end else if (slow_rise && !halted) begin
      presc_q <= presc_wrap ? 8'h00 : presc_q + 8'h01;
    end
  end

  // down counter; on underflow it reloads and keeps running
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      count_q <= {CNT_W{1'b1}};
    end else if (wr_mode && !mode_locked_q) begin
      count_q <= WDATA_I[`LOAD_MSB:`LOAD_LSB];
    end else if (restart_ok) begin
      count_q <= load_val;
    end else if (underflow) begin
      count_q <= load_val;
    end else if (tick) begin
      count_q <= count_q - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // sticky flags and held fault; a set in the read cycle wins
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      unf_q <= 1'b0;
      err_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      unf_q <= unf_set || (unf_q && !rd_stat);
      err_q <= err_set || (err_q && !rd_stat);
      fault_q <= fault_ev || (fault_q && !rd_stat);
    end
  end

  // registered outputs, one cycle after the flags they follow
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IRQ_O <= 1'b0;
      FAULT_ALL_O <= 1'b0;
      FAULT_PROC_O <= 1'b0;
    end else begin
      IRQ_O <= (unf_q || err_q) && mode_q[`INT_EN_BIT];
      FAULT_ALL_O <= fault_q && !mode_q[`PROC_ONLY_BIT];
      FAULT_PROC_O <= fault_q && mode_q[`PROC_ONLY_BIT];
    end
  end

  // read data in the cycle after the strobe; control reads as zero
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 32'h0000_0000;
    end else if (RD_I) begin
      case (ADDR_I)
        `OFS_WATCHDOG_MODE: RDATA_O <= mode_q;
        `OFS_WATCHDOG_STATUS: RDATA_O <= {30'h0000_0000, err_q, unf_q};
        default: RDATA_O <= 32'h0000_0000;
      endcase
    end else begin
      RDATA_O <= 32'h0000_0000;
    end
  end

endmodule

// ==== tb/windowed_watchdog_timer_sva.sv ====
// checker for the watchdog register port and fault outputs
// assumes it is bound to the watchdog top module
`timescale 1ns/1ps
module wdog_checker (
  // watched ports
  input wire REF_CLK_I,
  input wire RST_N_I,
  input wire [7:0] ADDR_I,
  input wire RD_I,
  input wire [31:0] RDATA_O,
  input wire IRQ_O,
  input wire FAULT_ALL_O,
  input wire FAULT_PROC_O
);
  // status read decode and combined fault
  wire st_rd = RD_I && ADDR_I == 8'h08;
  wire flt = FAULT_ALL_O | FAULT_PROC_O;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_st_rd;
    st_rd ##1 1'b1;
  endsequence
  chk_rdata_idle: assert property (
    !$past(RD_I) |-> RDATA_O == 0)
    else $error("read data not zero outside read");
  chk_fault_one: assert property (
    !(FAULT_ALL_O && FAULT_PROC_O))
    else $error("both fault kinds raised");
  chk_status_clear: assert property (
    s_st_rd |=> !flt && !IRQ_O)
    else $error("fault or irq kept after status read");
  chk_status_bits: assert property (
    s_st_rd |-> RDATA_O[31:2] == 0)
    else $error("status upper bits set");
  chk_mode_top: assert property (
    RD_I && ADDR_I == 8'h04 |=> RDATA_O[31:30] == 2'b00)
    else $error("mode upper bits set");
  chk_wo_read: assert property (
    RD_I && (ADDR_I == 8'h00 || ADDR_I > 8'h08) |=> RDATA_O == 0)
    else $error("control or unmapped read not zero");
  chk_fault_held: assert property (
    flt && !st_rd && !$past(st_rd) |=> flt)
    else $error("fault dropped without status read");
  chk_reset_quiet: assert property (
    $rose(RST_N_I) |-> !IRQ_O && !flt)
    else $error("outputs active after reset");
endmodule
bind windowed_watchdog_timer wdog_checker wdog_checker_inst (
  .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .IRQ_O(IRQ_O), .FAULT_ALL_O(FAULT_ALL_O),
  .FAULT_PROC_O(FAULT_PROC_O));

// ==== tb/slow_clock_source.sv ====
// slow clock model standing in for the low-speed oscillator
// assumes a free-running reference clock; the slow clock runs free
`timescale 1ns/1ps
module slow_clock_source #(
  parameter HALF = 4
) (
  // reference clock in
  input wire ref_clk_i,
  // slow clock out
  output reg slow_clk_o = 1'b0
);
  integer cnt = 0;
  // far faster than nominal, to keep the run short
  always @(posedge ref_clk_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      slow_clk_o <= ~slow_clk_o;
  end
endmodule

// ==== tb/windowed_watchdog_timer_test.sv ====
// self-checking bench for the windowed watchdog
// assumes the checker is bound and the slow clock model runs beside it
`timescale 1ns/1ps
module windowed_watchdog_timer_test;
  reg clk = 0, rst_n = 0, wr = 0, rd = 0;
  reg [7:0] addr = 0;
  reg [31:0] wdata = 0;
  reg dbg = 0, idle = 0;
  wire [31:0] rdata;
  wire slow, irq, f_all, f_proc;
  integer fails = 0, check_count = 0, cycles = 0, i;
  windowed_watchdog_timer #(.PRESCALE(2)) windowed_watchdog_timer_inst (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SLOW_CLK_I(slow),
    .DEBUG_STATE_I(dbg), .IDLE_MODE_I(idle), .IRQ_O(irq),
    .FAULT_ALL_O(f_all), .FAULT_PROC_O(f_proc));
  slow_clock_source slow_clock_source_inst (.ref_clk_i(clk),
    .slow_clk_o(slow));
  task finish_test;
    begin
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // let the edge's updates land before looking
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
    end
  endtask
  task rd_reg(input [7:0] a, input [31:0] exp);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1;
      check("read data", rdata, exp);
    end
  endtask
  initial forever #2.5 clk = ~clk;
  // hang guard: generous against the longest wait below
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      finish_test;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rd_reg(8'h04, 32'h3FFF_2FFF);
    rd_reg(8'h00, 0);
    rd_reg(8'h0C, 0);
    wr_reg(8'h00, 32'hA500_0001);
    rd_reg(8'h08, 0);
    // load 4, delta 2, irq, reset, processor only
    wr_reg(8'h04, 32'h0002_7004);
    wr_reg(8'h00, 32'h5A00_0001);
    rd_reg(8'h08, 0);
    wr_reg(8'h04, 32'h0000_0FFF);
    rd_reg(8'h04, 32'h0002_7004);
    wr_reg(8'h00, 32'hA500_0001);
    tick(2);
    check("irq", irq, 1);
    check("proc fault", f_proc, 1);
    rd_reg(8'h08, 2);
    tick(1);
    check("proc fault", f_proc, 0);
    for (i = 0; i < 400 && f_proc !== 1'b1; i = i + 1)
      tick(1);
    check("proc fault", f_proc, 1);
    rd_reg(8'h08, 1);
    // mid-run reset, released on an edge
    @(posedge clk);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rd_reg(8'h04, 32'h3FFF_2FFF);
    rd_reg(8'h08, 0);
    // disabled, load 1, delta 0, reset all
    wr_reg(8'h04, 32'h0000_A001);
    tick(100);
    rd_reg(8'h08, 0);
    wr_reg(8'h00, 32'hA500_0001);
    tick(2);
    check("all fault", f_all, 1);
    rd_reg(8'h08, 2);
    // halt test: both halts on, load 1, delta 1, reset all
    @(posedge clk);
    rst_n <= 0;
    dbg <= 1;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    wr_reg(8'h04, 32'h3001_2001);
    tick(100);
    rd_reg(8'h08, 0);
    @(posedge clk);
    dbg <= 0;
    idle <= 1;
    tick(100);
    rd_reg(8'h08, 0);
    @(posedge clk);
    idle <= 0;
    for (i = 0; i < 400 && f_all !== 1'b1; i = i + 1)
      tick(1);
    check("all fault", f_all, 1);
    rd_reg(8'h08, 1);
    finish_test;
  end
endmodule
